//--- src/sdid_decoder.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sdid_cfg.svh"

// Function
// [RULE1] torque source code is {code 17, code 16}
// [RULE2] speed/position dual mode: code 18 off speed, on position
// [RULE3] speed/torque dual mode: code 19 off speed, on torque
// [RULE4] torque/position dual mode: code 20 off torque, on position
// [RULE5] emergency stop is normally closed; dropping raises emergency fault
// [RULE6] reverse limit is normally closed; dropping raises reverse fault
// [RULE7] forward limit is normally closed; dropping raises forward fault
// [RULE8] code 24 activation starts home sensor search
// [RULE9] directional torque limits apply only while limit enable is set
// [RULE10] code 27 activation commands move to home
// [RULE11] feed step select is codes 28..32, bit 0 to bit 4
// [RULE12] feed step mode is codes 33 and 34, bit 0 and bit 1
// [RULE13] code 35 requests manual continuous, code 36 manual single step
// [RULE14] codes 37 and 38 jog forward and reverse while active
// [RULE15] code 39 activation moves to next stored position
// [RULE16] code 40 activation moves to previous stored position
// [RULE17] code 41 activation returns to first stored position
// [RULE18] code 42 steps through positions, waiting configured interval
// [RULE19] codes 43 and 44 select the gear numerator
// [RULE20] code 45 inhibits external pulses while in position mode
// [RULE21] each input line has a configurable active polarity
// [RULE22] lines map to configured codes; unassigned codes stay inactive
module sdid_decoder (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                ce,
    input  wire logic [7:0]          inputPins,
    input  wire logic [7:0]          regAddr,
    input  wire logic [31:0]         regWdata,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic      [31:0]         regRdata,
    output logic      [1:0]          torqueSrcSel,
    output sdid_pkg::sdid_loop_t     ctrlMode,
    output logic                     faultEmergencyStop,
    output logic                     faultReverseLimit,
    output logic                     faultForwardLimit,
    output logic                     homeSearchStart,
    output logic                     goHomeStart,
    output logic                     reverseTorqueLimit,
    output logic                     forwardTorqueLimit,
    output logic      [4:0]          feedStepSel,
    output logic      [1:0]          feedMode,
    output logic                     manualContinuous,
    output logic                     manualSingleStep,
    output logic                     jogForward,
    output logic                     jogReverse,
    output logic      [2:0]          posIndex,
    output logic                     posMoveStart,
    output logic      [1:0]          gearNumerSel,
    output logic                     pulseCmdInhibit
);

    // ------------------------------------------------------------
    // line decode
    // ------------------------------------------------------------
    function automatic logic [63:0] decodeLines(
        input logic [7:0]      lvl,
        input logic [7:0][5:0] codes
    );
        logic [63:0] v;
        v = 64'h0;
        for (int i = 0; i < `SDID_NUM_LINES; i++) begin
            if (codes[i] != 6'h00 && lvl[i]) begin
                v[codes[i]] = 1'b1;
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [7:0] pinMeta;
    logic [7:0] pinSync;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pinMeta <= 8'h00;
            pinSync <= 8'h00;
        end else if (ce) begin
            pinMeta <= inputPins;
            pinSync <= pinMeta;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0][5:0]        lineCode;
    logic [7:0]             linePol;
    sdid_pkg::sdid_opmode_t modeSel;
    logic                   torqueLimitEn;
    logic [15:0]            autoInterval;
    logic [7:0][5:0]        next_lineCode;
    logic [7:0]             next_linePol;
    sdid_pkg::sdid_opmode_t next_modeSel;
    logic                   next_torqueLimitEn;
    logic [15:0]            next_autoInterval;
    logic [31:0]            next_regRdata;
    logic [2:0]             faultClr;
    logic [63:0]            fa;
    logic [63:0]            assigned;
    logic [63:0]            faPrev;

    // polarity flips each line before the code mapping
    assign fa       = decodeLines(pinSync ^ linePol, lineCode); // see [RULE21]
    assign assigned = decodeLines(8'hFF, lineCode);             // see [RULE22]

    always_comb begin
        next_lineCode      = lineCode;
        next_linePol       = linePol;
        next_modeSel       = modeSel;
        next_torqueLimitEn = torqueLimitEn;
        next_autoInterval  = autoInterval;
        next_regRdata      = 32'h0000_0000;
        faultClr           = 3'h0;
        if (regWrite) begin
            if (regAddr < 8'(`SDID_NUM_LINES)) begin
                next_lineCode[regAddr[2:0]] =
                    regWdata[`SDID_LINE_CODE_MSB:`SDID_LINE_CODE_LSB];
                next_linePol[regAddr[2:0]] = regWdata[`SDID_LINE_POL_BIT];
            end else begin
                case (regAddr)
                    `SDID_OFS_CTRL: begin
                        next_modeSel = sdid_pkg::sdid_opmode_t'(
                            regWdata[`SDID_CTRL_MODE_MSB:`SDID_CTRL_MODE_LSB]);
                        next_torqueLimitEn = regWdata[`SDID_CTRL_TLEN_BIT];
                    end
                    `SDID_OFS_INTERVAL: next_autoInterval = regWdata[15:0];
                    `SDID_OFS_FAULT:    faultClr = regWdata[2:0];
                    default: ;
                endcase
            end
        end
        if (regRead) begin
            if (regAddr < 8'(`SDID_NUM_LINES)) begin
                next_regRdata[`SDID_LINE_CODE_MSB:`SDID_LINE_CODE_LSB] =
                    lineCode[regAddr[2:0]];
                next_regRdata[`SDID_LINE_POL_BIT] = linePol[regAddr[2:0]];
            end else begin
                case (regAddr)
                    `SDID_OFS_CTRL:
                        next_regRdata[3:0] = {torqueLimitEn, modeSel};
                    `SDID_OFS_INTERVAL: next_regRdata[15:0] = autoInterval;
                    `SDID_OFS_FAULT: next_regRdata[2:0] = {faultForwardLimit,
                        faultReverseLimit, faultEmergencyStop};
                    `SDID_OFS_STATUS: next_regRdata[6:0] = {pulseCmdInhibit,
                        autoState, posIndex, ctrlMode};
                    `SDID_OFS_FUNC_LO:  next_regRdata = fa[31:0];
                    `SDID_OFS_FUNC_HI:  next_regRdata = fa[63:32];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lineCode      <= {8{`SDID_RST_LINE_CODE}};
            linePol       <= {8{`SDID_RST_LINE_POL}};
            modeSel       <= sdid_pkg::sdid_opmode_t'(`SDID_RST_MODE);
            torqueLimitEn <= `SDID_RST_TLEN;
            autoInterval  <= `SDID_RST_INTERVAL;
            regRdata      <= 32'h0000_0000;
        end else if (ce) begin
            lineCode      <= next_lineCode;
            linePol       <= next_linePol;
            modeSel       <= next_modeSel;
            torqueLimitEn <= next_torqueLimitEn;
            autoInterval  <= next_autoInterval;
            regRdata      <= next_regRdata;
        end
    end

    // ------------------------------------------------------------
    // function decode and motion actions
    // ------------------------------------------------------------
    sdid_pkg::sdid_auto_t autoState;
    sdid_pkg::sdid_auto_t next_autoState;
    logic [15:0]          autoCount;
    logic [15:0]          next_autoCount;
    sdid_pkg::sdid_loop_t next_ctrlMode;
    logic [2:0]           next_posIndex;
    logic                 next_posMoveStart;
    logic [2:0]           next_fault;
    logic [63:0]          rise;

    assign rise = fa & ~faPrev;

    always_comb begin
        case (modeSel)
            sdid_pkg::OPM_SPEED:    next_ctrlMode = sdid_pkg::LOOP_SPEED;
            sdid_pkg::OPM_POSITION: next_ctrlMode = sdid_pkg::LOOP_POSITION;
            sdid_pkg::OPM_TORQUE:   next_ctrlMode = sdid_pkg::LOOP_TORQUE;
            sdid_pkg::OPM_SPD_POS: begin
                next_ctrlMode = fa[`SDID_FC_SP] ? sdid_pkg::LOOP_POSITION
                                                : sdid_pkg::LOOP_SPEED; // see [RULE2]
            end
            sdid_pkg::OPM_SPD_TRQ: begin
                next_ctrlMode = fa[`SDID_FC_ST] ? sdid_pkg::LOOP_TORQUE
                                                : sdid_pkg::LOOP_SPEED; // see [RULE3]
            end
            sdid_pkg::OPM_TRQ_POS: begin
                next_ctrlMode = fa[`SDID_FC_TP] ? sdid_pkg::LOOP_POSITION
                                                : sdid_pkg::LOOP_TORQUE; // see [RULE4]
            end
            default: next_ctrlMode = sdid_pkg::LOOP_SPEED;
        endcase

        // set wins over software clear
        next_fault[0] = (faultEmergencyStop & ~faultClr[0])
            | (assigned[`SDID_FC_EMG] & ~fa[`SDID_FC_EMG]);       // see [RULE5]
        next_fault[1] = (faultReverseLimit & ~faultClr[1])
            | (assigned[`SDID_FC_REVLIM] & ~fa[`SDID_FC_REVLIM]); // see [RULE6]
        next_fault[2] = (faultForwardLimit & ~faultClr[2])
            | (assigned[`SDID_FC_FWDLIM] & ~fa[`SDID_FC_FWDLIM]); // see [RULE7]

        // auto-run sequencer
        next_autoState    = autoState;
        next_autoCount    = autoCount;
        next_posIndex     = posIndex;
        next_posMoveStart = 1'b0;
        case (autoState)
            sdid_pkg::AUTO_IDLE: begin
                next_autoCount = 16'h0000;
                if (fa[`SDID_FC_AUTORUN]) begin
                    next_autoState = sdid_pkg::AUTO_WAIT;             // see [RULE18]
                end
            end
            sdid_pkg::AUTO_WAIT: begin
                if (!fa[`SDID_FC_AUTORUN]) begin
                    next_autoState = sdid_pkg::AUTO_IDLE;
                end else if (autoCount >= autoInterval) begin
                    next_autoCount    = 16'h0000;
                    next_posIndex     = posIndex + 3'h1;             // see [RULE18]
                    next_posMoveStart = 1'b1;
                end else begin
                    next_autoCount = autoCount + 16'h0001;
                end
            end
            default: next_autoState = sdid_pkg::AUTO_IDLE;
        endcase

        // manual steps override the sequencer
        if (rise[`SDID_FC_STEPFIRST]) begin
            next_posIndex     = 3'h0;                                // see [RULE17]
            next_posMoveStart = 1'b1;
        end else if (rise[`SDID_FC_STEPNEXT]) begin
            next_posIndex     = posIndex + 3'h1;                     // see [RULE15]
            next_posMoveStart = 1'b1;
        end else if (rise[`SDID_FC_STEPPREV]) begin
            next_posIndex     = posIndex - 3'h1;                     // see [RULE16]
            next_posMoveStart = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            faPrev             <= 64'h0;
            autoState          <= sdid_pkg::AUTO_IDLE;
            autoCount          <= 16'h0000;
            posIndex           <= 3'h0;
            posMoveStart       <= 1'b0;
            ctrlMode           <= sdid_pkg::LOOP_SPEED;
            torqueSrcSel       <= 2'h0;
            faultEmergencyStop <= 1'b0;
            faultReverseLimit  <= 1'b0;
            faultForwardLimit  <= 1'b0;
            homeSearchStart    <= 1'b0;
            goHomeStart        <= 1'b0;
            reverseTorqueLimit <= 1'b0;
            forwardTorqueLimit <= 1'b0;
            feedStepSel        <= 5'h00;
            feedMode           <= 2'h0;
            manualContinuous   <= 1'b0;
            manualSingleStep   <= 1'b0;
            jogForward         <= 1'b0;
            jogReverse         <= 1'b0;
            gearNumerSel       <= 2'h0;
            pulseCmdInhibit    <= 1'b0;
        end else if (ce) begin
            faPrev             <= fa;
            autoState          <= next_autoState;
            autoCount          <= next_autoCount;
            posIndex           <= next_posIndex;
            posMoveStart       <= next_posMoveStart;
            ctrlMode           <= next_ctrlMode;
            torqueSrcSel       <= fa[`SDID_FC_TCM_HI:`SDID_FC_TCM_LO]; // see [RULE1]
            faultEmergencyStop <= next_fault[0];
            faultReverseLimit  <= next_fault[1];
            faultForwardLimit  <= next_fault[2];
            homeSearchStart    <= rise[`SDID_FC_HOMESRCH];         // see [RULE8]
            goHomeStart        <= rise[`SDID_FC_GOHOME];           // see [RULE10]
            reverseTorqueLimit <= torqueLimitEn & fa[`SDID_FC_REVTQ]; // see [RULE9]
            forwardTorqueLimit <= torqueLimitEn & fa[`SDID_FC_FWDTQ]; // see [RULE9]
            feedStepSel        <= fa[`SDID_FC_FEED_B4:`SDID_FC_FEED_B0]; // see [RULE11]
            feedMode           <= fa[`SDID_FC_MODE_B1:`SDID_FC_MODE_B0]; // see [RULE12]
            manualContinuous   <= fa[`SDID_FC_MANCONT];            // see [RULE13]
            manualSingleStep   <= fa[`SDID_FC_MANSTEP];            // see [RULE13]
            // both jog requests at once cancel each other
            jogForward <= fa[`SDID_FC_JOGFWD] & ~fa[`SDID_FC_JOGREV]; // see [RULE14]
            jogReverse <= fa[`SDID_FC_JOGREV] & ~fa[`SDID_FC_JOGFWD]; // see [RULE14]
            gearNumerSel <= fa[`SDID_FC_GEAR_HI:`SDID_FC_GEAR_LO];    // see [RULE19]
            pulseCmdInhibit <= fa[`SDID_FC_INHIBIT]
                & (next_ctrlMode == sdid_pkg::LOOP_POSITION);       // see [RULE20]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_torque_src_code: // see [RULE1]
        assert property (ce |=> torqueSrcSel == $past(fa[17:16]))
        else $error("torque source code mismatch");
    a_dual_sp_switch: // see [RULE2]
        assert property (ce && modeSel == sdid_pkg::OPM_SPD_POS
            && fa[18] |=> ctrlMode == sdid_pkg::LOOP_POSITION)
        else $error("speed/position switch wrong");
    a_dual_st_switch: // see [RULE3]
        assert property (ce && modeSel == sdid_pkg::OPM_SPD_TRQ
            && !fa[19] |=> ctrlMode == sdid_pkg::LOOP_SPEED)
        else $error("speed/torque switch wrong");
    a_emg_fault_set: // see [RULE5]
        assert property (ce && assigned[21] && !fa[21]
            |=> faultEmergencyStop [*2])
        else $error("emergency fault not raised");
    a_rev_fault_set: // see [RULE6]
        assert property (ce && assigned[22] && !fa[22] |=> faultReverseLimit)
        else $error("reverse fault not raised");
    a_fwd_fault_set: // see [RULE7]
        assert property (ce && assigned[23] && !fa[23] |=> faultForwardLimit)
        else $error("forward fault not raised");
    a_home_search_pulse: // see [RULE8]
        assert property (ce && fa[24] && !faPrev[24] |=> homeSearchStart)
        else $error("home search not started");
    a_torque_limit_gate: // see [RULE9]
        assert property (ce && !torqueLimitEn
            |=> !reverseTorqueLimit && !forwardTorqueLimit)
        else $error("torque limit applied while disabled");
    a_step_first_index: // see [RULE17]
        assert property (ce && rise[41] |=> posIndex == 3'h0 && posMoveStart)
        else $error("step to first failed");
    a_step_next_index: // see [RULE15]
        assert property (ce && rise[39] && !rise[41]
            |=> posIndex == $past(posIndex) + 3'h1)
        else $error("step next failed");
    a_auto_run_stop: // see [RULE18]
        assert property (ce && !fa[42] |=> autoState == sdid_pkg::AUTO_IDLE)
        else $error("auto run continued without request");
    a_pulse_inhibit_mode: // see [RULE20]
        assert property (pulseCmdInhibit
            |-> ctrlMode == sdid_pkg::LOOP_POSITION)
        else $error("pulse inhibit outside position mode");

    c_emg_fault:  cover property (ce && faultEmergencyStop);
    c_auto_step:  cover property (autoState == sdid_pkg::AUTO_WAIT
        ##1 posMoveStart);
    c_mode_swap:  cover property (ctrlMode == sdid_pkg::LOOP_SPEED
        ##1 ctrlMode == sdid_pkg::LOOP_POSITION);

endmodule // sdid_decoder
`default_nettype wire

//--- inc/sdid_cfg.svh
`ifndef SDID_CFG_SVH
`define SDID_CFG_SVH

// register offsets
`define SDID_OFS_LINE0      8'h00
`define SDID_OFS_CTRL       8'h08
`define SDID_OFS_INTERVAL   8'h09
`define SDID_OFS_FAULT      8'h0A
`define SDID_OFS_STATUS     8'h0B
`define SDID_OFS_FUNC_LO    8'h0C
`define SDID_OFS_FUNC_HI    8'h0D

// line config fields
`define SDID_LINE_CODE_MSB  5
`define SDID_LINE_CODE_LSB  0
`define SDID_LINE_POL_BIT   7

// control fields
`define SDID_CTRL_MODE_MSB  2
`define SDID_CTRL_MODE_LSB  0
`define SDID_CTRL_TLEN_BIT  3

// reset values
`define SDID_RST_LINE_CODE  6'h00
`define SDID_RST_LINE_POL   1'h0
`define SDID_RST_MODE       3'h0
`define SDID_RST_TLEN       1'h0
`define SDID_RST_INTERVAL   16'h03E8

// function codes
`define SDID_FC_TCM_LO      16
`define SDID_FC_TCM_HI      17
`define SDID_FC_SP          18
`define SDID_FC_ST          19
`define SDID_FC_TP          20
`define SDID_FC_EMG         21
`define SDID_FC_REVLIM      22
`define SDID_FC_FWDLIM      23
`define SDID_FC_HOMESRCH    24
`define SDID_FC_REVTQ       25
`define SDID_FC_FWDTQ       26
`define SDID_FC_GOHOME      27
`define SDID_FC_FEED_B0     28
`define SDID_FC_FEED_B4     32
`define SDID_FC_MODE_B0     33
`define SDID_FC_MODE_B1     34
`define SDID_FC_MANCONT     35
`define SDID_FC_MANSTEP     36
`define SDID_FC_JOGFWD      37
`define SDID_FC_JOGREV      38
`define SDID_FC_STEPNEXT    39
`define SDID_FC_STEPPREV    40
`define SDID_FC_STEPFIRST   41
`define SDID_FC_AUTORUN     42
`define SDID_FC_GEAR_LO     43
`define SDID_FC_GEAR_HI     44
`define SDID_FC_INHIBIT     45

`define SDID_NUM_LINES      8
`define SDID_LAST_POS       3'h7

`endif

//--- inc/sdid_pkg.sv
package sdid_pkg;

    typedef enum logic [2:0] {
        OPM_SPEED    = 3'h0,
        OPM_POSITION = 3'h1,
        OPM_TORQUE   = 3'h2,
        OPM_SPD_POS  = 3'h3,
        OPM_SPD_TRQ  = 3'h4,
        OPM_TRQ_POS  = 3'h5
    } sdid_opmode_t;

    typedef enum logic [1:0] {
        LOOP_SPEED    = 2'h0,
        LOOP_POSITION = 2'h1,
        LOOP_TORQUE   = 2'h2
    } sdid_loop_t;

    typedef enum logic [0:0] {
        AUTO_IDLE = 1'h0,
        AUTO_WAIT = 1'h1
    } sdid_auto_t;

endpackage

//--- verification/sdid_switch_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// switch bank driving the input lines
// ----------------------------------------
module sdid_switch_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [7:0] want,
    output logic      [7:0] pins
);
    logic [7:0] next_pins;

    // closed contacts stay closed until commanded open
    always_comb begin
        next_pins = want;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pins <= 8'h00;
        end else begin
            pins <= next_pins;
        end
    end
endmodule // sdid_switch_model

`default_nettype wire

//--- verification/servo_digital_input_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none

module servo_digital_input_decoder_bench;
    logic                 mclk, reset, regWrite, regRead;
    logic [7:0]           regAddr, want, inputPins;
    logic [31:0]          regWdata, regRdata;
    logic [1:0]           torqueSrcSel, feedMode, gearNumerSel;
    logic [4:0]           feedStepSel;
    logic [2:0]           posIndex, p;
    sdid_pkg::sdid_loop_t ctrlMode;
    logic                 faultEmergencyStop, faultReverseLimit;
    logic                 faultForwardLimit, homeSearchStart, goHomeStart;
    logic                 reverseTorqueLimit, forwardTorqueLimit;
    logic                 manualContinuous, manualSingleStep;
    logic                 jogForward, jogReverse, posMoveStart;
    logic                 pulseCmdInhibit;
    int                   num_errors, cmp_count, n, cH, cG, cM;
    wire  [16:0]          obs = {torqueSrcSel, reverseTorqueLimit,
        forwardTorqueLimit, feedStepSel, feedMode, manualContinuous,
        manualSingleStep, jogForward, jogReverse, gearNumerSel};
    wire  [2:0]           flt = {faultForwardLimit, faultReverseLimit,
        faultEmergencyStop};
    int lvlCode [17] = '{43, 44, 38, 37, 36, 35, 33, 34, 28, 29, 30, 31,
        32, 26, 25, 16, 17};
    int mTab [6][4] = '{'{0, 0, 0, 0}, '{1, 0, 1, 1}, '{2, 0, 2, 2},
        '{3, 18, 0, 1}, '{4, 19, 0, 2}, '{5, 20, 2, 1}};
    int sCode [7] = '{24, 27, 39, 39, 40, 41, 40};
    int sCnt  [7] = '{256, 16, 1, 1, 1, 1, 1};
    int sIdx  [7] = '{0, 0, 1, 2, 1, 0, 7};

    sdid_switch_model sw (.mclk(mclk), .reset(reset), .want(want),
        .pins(inputPins));

    sdid_decoder dut (.mclk(mclk), .reset(reset), .ce(1'b1),
        .inputPins(inputPins), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .torqueSrcSel(torqueSrcSel), .ctrlMode(ctrlMode),
        .faultEmergencyStop(faultEmergencyStop),
        .faultReverseLimit(faultReverseLimit),
        .faultForwardLimit(faultForwardLimit),
        .homeSearchStart(homeSearchStart), .goHomeStart(goHomeStart),
        .reverseTorqueLimit(reverseTorqueLimit),
        .forwardTorqueLimit(forwardTorqueLimit), .feedStepSel(feedStepSel),
        .feedMode(feedMode), .manualContinuous(manualContinuous),
        .manualSingleStep(manualSingleStep), .jogForward(jogForward),
        .jogReverse(jogReverse), .posIndex(posIndex),
        .posMoveStart(posMoveStart), .gearNumerSel(gearNumerSel),
        .pulseCmdInhibit(pulseCmdInhibit));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 chk(regRdata, e);
    endtask

    // pin change, then let sync and decode settle
    task automatic pin(input int i, input logic v);
        @(posedge mclk);
        want[i] <= v;
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic waitMove;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (posMoveStart !== 1'b1 && n < 40);
        if (n >= 40) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic testRegs;
        rd(8'h08, 32'h0);
        rd(8'h09, 32'h3E8);
        rd(8'h00, 32'h0);
        wr(8'hFF, 32'hFFFFFFFF);
        rd(8'hFF, 32'h0);
        want <= 8'hFF;
        pin(0, 1'b1);
        chk(obs, 32'h0);
        chk(flt, 32'h0);
        pin(7, 1'b0);
        want <= 8'h00;
        $display("registers done");
    endtask

    task automatic testLevels;
        wr(8'h08, 32'h8);
        for (int i = 0; i < 17; i++) begin
            wr(8'h00, lvlCode[i]);
            pin(0, 1'b1);
            chk(obs, 1 << i);
            pin(0, 1'b0);
        end
        wr(8'h08, 32'h0);
        wr(8'h00, 32'd25);
        pin(0, 1'b1);
        chk(obs, 32'h0);
        pin(0, 1'b0);
        wr(8'h00, 32'hA5);
        rd(8'h00, 32'hA5);
        pin(0, 1'b0);
        chk(obs, 32'h8);
        wr(8'h00, 32'h0);
        $display("levels done");
    endtask

    task automatic testModes;
        wr(8'h01, 32'd45);
        pin(1, 1'b1);
        for (int r = 0; r < 6; r++) begin
            wr(8'h08, mTab[r][0]);
            wr(8'h02, mTab[r][1]);
            pin(2, 1'b0);
            chk(ctrlMode, mTab[r][2]);
            chk(pulseCmdInhibit, mTab[r][2] == 1);
            pin(2, 1'b1);
            chk(ctrlMode, mTab[r][3]);
            chk(pulseCmdInhibit, mTab[r][3] == 1);
        end
        wr(8'h01, 32'h0);
        wr(8'h02, 32'h0);
        wr(8'h08, 32'h0);
        $display("modes done");
    endtask

    task automatic testFaults;
        pin(2, 1'b1);
        for (int k = 0; k < 3; k++) begin
            wr(8'h02, 21 + k);
            pin(2, 1'b1);
            chk(flt, 32'h0);
            pin(2, 1'b0);
            pin(2, 1'b1);
            chk(flt, 1 << k);
            rd(8'h0A, 1 << k);
            wr(8'h0A, 32'h7);
            pin(2, 1'b1);
            chk(flt, 32'h0);
        end
        wr(8'h02, 32'h0);
        pin(2, 1'b0);
        $display("faults done");
    endtask

    task automatic testSteps;
        for (int s = 0; s < 7; s++) begin
            pin(3, 1'b0);
            wr(8'h03, sCode[s]);
            pin(3, 1'b0);
            @(posedge mclk);
            want[3] <= 1'b1;
            cH = 0;
            cG = 0;
            cM = 0;
            repeat (12) begin
                @(posedge mclk);
                #1 cH += homeSearchStart;
                cG += goHomeStart;
                cM += posMoveStart;
            end
            chk(cH * 256 + cG * 16 + cM, sCnt[s]);
            chk(posIndex, sIdx[s]);
        end
        pin(3, 1'b0);
        wr(8'h03, 32'h0);
        $display("steps done");
    endtask

    task automatic testAuto;
        wr(8'h09, 32'h4);
        wr(8'h04, 32'd42);
        @(posedge mclk);
        want[4] <= 1'b1;
        waitMove();
        p = posIndex;
        waitMove();
        chk(n, 5);
        chk(posIndex, p + 3'h1);
        pin(4, 1'b0);
        wr(8'h04, 32'h0);
        $display("auto run done");
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        reset = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        want = 8'h00;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        testRegs();
        testLevels();
        testModes();
        testFaults();
        testSteps();
        testAuto();
        tally_and_finish();
    end
endmodule // servo_digital_input_decoder_bench

`default_nettype wire
